// >>> design/mtx_pkg.sv
// constants and types of the coded serial transmitter
package mtx_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_STATUS = 16'hFF47;
    localparam logic [15:0] ADDR_TXBUF  = 16'hFF4A;
    localparam logic [15:0] ADDR_BITCNT = 16'hFF4B;
    localparam logic [15:0] ADDR_CTRL0  = 16'hFF4C;
    localparam logic [15:0] ADDR_CLKSEL = 16'hFF4D;
    localparam logic [15:0] ADDR_RATE   = 16'hFF4E;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned EN_BIT   = 7;
    localparam int unsigned DIR_BIT  = 4;
    localparam int unsigned FMT_BIT  = 1;
    localparam int unsigned IDLE_BIT = 0;
    localparam int unsigned BUSY_BIT = 7;

    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL0_RST   = 8'h10;
    localparam logic [7:0] CLKSEL_RST  = 8'h00;
    localparam logic [7:0] RATE_RST    = 8'h1F;
    localparam logic [7:0] STATUS_RST  = 8'h00;
    localparam logic [7:0] TXBUF_RST   = 8'hFF;
    localparam logic [7:0] BITCNT_RST  = 8'h07;
    localparam logic [7:0] CTRL0_MASK  = 8'h93;
    localparam logic [7:0] CLKSEL_MASK = 8'h07;
    localparam logic [7:0] RATE_MASK   = 8'h1F;
    localparam logic [7:0] BITCNT_MASK = 8'h07;

    // ------------------------------------------------------------
    // divider figures and queue depth
    // ------------------------------------------------------------
    localparam logic [4:0] K_MIN      = 5'h04;
    localparam logic [4:0] PRE_ZERO   = 5'h00;
    localparam int unsigned FIFO_DEPTH = 16;

    // one queued byte with its last bit index (bit count minus one)
    typedef struct packed {
        logic [7:0] data;
        logic [2:0] last;
    } mtx_word_t;

    // decoded main control fields
    typedef struct packed {
        logic en;
        logic lsb_first;
        logic seq_fmt;
        logic idle_hi;
    } mtx_ctrl_t;

endpackage : mtx_pkg

// >>> design/mtx_top.sv
// coded serial transmitter: byte queue and control/status logic
`timescale 1ns/1ps

// ----------------------------------------------------------------
// byte queue
// ----------------------------------------------------------------
module mtx_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clock_i,
    input  wire logic             srst_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    // handshakes on both sides
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign cnt_d       = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data_o  = mem_q[rd_q];
    assign out_valid_o = (cnt_q != '0);

    // storage carries no reset; pointers, count and ready flag do
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // pointers and an honest full flag held in a flop
    always_ff @(posedge clock_i) begin
        if (srst_i || flush_i) begin
            wr_q       <= '0;
            rd_q       <= '0;
            cnt_q      <= '0;
            in_ready_o <= 1'b1;
        end else begin
            wr_q       <= push ? wr_q + AW'(1) : wr_q;
            rd_q       <= pop ? rd_q + AW'(1) : rd_q;
            cnt_q      <= cnt_d;
            in_ready_o <= (cnt_d != (AW+1)'(DEPTH));
        end
    end

endmodule : mtx_fifo

// Behaviour
// - control bit 7 runs the transmitter when 1, stops it when 0
// - bit 4 first-bit order, bit 1 format, bit 0 idle output level
// - clock select codes 0..5 divide peripheral clock by 1..32
// - divider k equals field value 4..31; values below 4 act as 4
// - bit rate is base clock over two times k
// - status readable by bit or byte; writes to it do nothing
// - status clears on reset and whenever the enable bit is 0
// - busy reads 1 during transmission, 0 when done with no new data
// - busy stays 1 across bytes in continuous transmission
// - while disabled nothing is sent and the dividers stay still
// - while disabled the output pin is released to the port
// - buffer write while enabled starts transmission; buffer resets FFH
// - bit count field sends value plus one bits; resets to 7
// - short transfers send the lower buffer bits in either order
// - each transmission start raises the start interrupt request
module mtx_top #(
    parameter int unsigned DEPTH = mtx_pkg::FIFO_DEPTH
) (
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic        bus_wr_i,
    input  wire logic        bus_rd_i,
    input  wire logic        bus_bit_i,
    input  wire logic [2:0]  bus_bit_sel_i,
    input  wire logic [7:0]  bus_wdata_i,
    output logic [7:0]       bus_rdata_o,
    output logic             tx_buf_ready_o,
    output logic             coded_output_pin_o,
    output logic             coded_output_pin_oe_o,
    output logic             transmit_start_interrupt_o
);
    typedef enum logic {ST_IDLE, ST_SEND} mtx_state_t;

    logic [7:0]         ctrl0_q;
    logic [7:0]         clksel_q;
    logic [7:0]         rate_q;
    logic [7:0]         txbuf_q;
    logic [7:0]         bitcnt_q;
    logic               busy_q;
    mtx_state_t         state_q;
    logic [4:0]         pre_q;
    logic [4:0]         kc_q;
    logic               phase_q;
    logic [7:0]         sh_q;
    logic [2:0]         idx_q;
    logic [2:0]         rem_q;
    logic               pin_q;
    logic               oe_q;
    logic               irq_q;
    logic [7:0]         rdata_q;
    mtx_pkg::mtx_ctrl_t ctl;
    mtx_pkg::mtx_word_t push_word;
    mtx_pkg::mtx_word_t head;
    logic               head_valid;
    logic               fifo_ready;
    logic               wr_ctrl0;
    logic               wr_clksel;
    logic               wr_rate;
    logic               wr_txbuf;
    logic               wr_bitcnt;
    logic               push;
    logic               load;
    logic               base_tick;
    logic               half_tick;
    logic               bit_end;
    logic [4:0]         k_eff;
    logic [7:0]         ctrl0_wr;
    logic               cur_bit;
    logic               pin_d;

    // merge a one-bit write into a byte, or take the whole byte
    function automatic logic [7:0] merge8(input logic [7:0] old,
                                          input logic [7:0] wdat,
                                          input logic       bit_op,
                                          input logic [2:0] sel,
                                          input logic [7:0] mask);
        logic [7:0] one;
        one = 8'h01 << sel;
        if (bit_op) begin
            merge8 = ((old & ~one) | (wdat[0] ? one : 8'h00)) & mask;
        end else begin
            merge8 = wdat & mask;
        end
    endfunction : merge8

    // base clock mask: tick when the low n prescaler bits are all ones
    function automatic logic [4:0] sel_mask(input logic [2:0] sel);
        unique case (sel)
            3'h0:    sel_mask = 5'h00;
            3'h1:    sel_mask = 5'h01;
            3'h2:    sel_mask = 5'h03;
            3'h3:    sel_mask = 5'h07;
            3'h4:    sel_mask = 5'h0F;
            default: sel_mask = 5'h1F; // prohibited codes fall back to /32
        endcase
    endfunction : sel_mask

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    assign ctl.en        = ctrl0_q[mtx_pkg::EN_BIT];
    assign ctl.lsb_first = ctrl0_q[mtx_pkg::DIR_BIT];
    assign ctl.seq_fmt   = ctrl0_q[mtx_pkg::FMT_BIT];
    assign ctl.idle_hi   = ctrl0_q[mtx_pkg::IDLE_BIT];
    assign wr_ctrl0      = bus_wr_i && bus_addr_i == mtx_pkg::ADDR_CTRL0;
    // byte-only registers ignore single-bit writes
    assign wr_clksel     = bus_wr_i && !bus_bit_i
                           && bus_addr_i == mtx_pkg::ADDR_CLKSEL;
    assign wr_rate       = bus_wr_i && !bus_bit_i
                           && bus_addr_i == mtx_pkg::ADDR_RATE;
    assign wr_txbuf      = bus_wr_i && !bus_bit_i
                           && bus_addr_i == mtx_pkg::ADDR_TXBUF;
    assign wr_bitcnt     = bus_wr_i && !bus_bit_i
                           && bus_addr_i == mtx_pkg::ADDR_BITCNT;
    assign ctrl0_wr      = merge8(ctrl0_q, bus_wdata_i, bus_bit_i,
                                  bus_bit_sel_i, mtx_pkg::CTRL0_MASK);

    // ------------------------------------------------------------
    // queue feed: byte plus its bit count, only while enabled
    // ------------------------------------------------------------
    assign push           = wr_txbuf && ctl.en;
    assign push_word.data = bus_wdata_i;
    assign push_word.last = bitcnt_q[2:0];

    mtx_fifo #(
        .WIDTH ($bits(mtx_pkg::mtx_word_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .srst_i      (srst_i),
        .flush_i     (!ctl.en),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (push_word),
        .out_valid_o (head_valid),
        .out_ready_i (load),
        .out_data_o  (head)
    );

    // ------------------------------------------------------------
    // baud generation and sequencing terms
    // ------------------------------------------------------------
    assign k_eff     = (rate_q[4:2] == 3'h0) ? mtx_pkg::K_MIN
                                             : rate_q[4:0];
    assign base_tick = (pre_q & sel_mask(clksel_q[2:0]))
                       == sel_mask(clksel_q[2:0]);
    // one counter period is half a bit, so a bit spans 2k base ticks
    assign half_tick = state_q == ST_SEND && base_tick
                       && kc_q == k_eff - 5'h01;
    assign bit_end   = half_tick && phase_q;
    assign load      = ctl.en && head_valid
                       && (state_q == ST_IDLE
                           || (bit_end && rem_q == 3'h0));
    assign cur_bit   = sh_q[idx_q];
    assign pin_d     = (state_q != ST_SEND) ? ctl.idle_hi
                     : ctl.seq_fmt ? cur_bit
                     : (phase_q ? cur_bit : !cur_bit);

    // control and setup registers
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ctrl0_q  <= mtx_pkg::CTRL0_RST;
            clksel_q <= mtx_pkg::CLKSEL_RST;
            rate_q   <= mtx_pkg::RATE_RST;
            txbuf_q  <= mtx_pkg::TXBUF_RST;
            bitcnt_q <= mtx_pkg::BITCNT_RST;
        end else begin
            ctrl0_q  <= wr_ctrl0 ? ctrl0_wr : ctrl0_q;
            clksel_q <= wr_clksel ? bus_wdata_i & mtx_pkg::CLKSEL_MASK
                                  : clksel_q;
            rate_q   <= wr_rate ? bus_wdata_i & mtx_pkg::RATE_MASK
                                : rate_q;
            txbuf_q  <= wr_txbuf ? bus_wdata_i : txbuf_q;
            bitcnt_q <= wr_bitcnt ? bus_wdata_i & mtx_pkg::BITCNT_MASK
                                  : bitcnt_q;
        end
    end

    // dividers run only during a transfer to keep the clocking still
    always_ff @(posedge clock_i) begin
        if (srst_i || !ctl.en || load || state_q != ST_SEND) begin
            pre_q <= mtx_pkg::PRE_ZERO;
            kc_q  <= mtx_pkg::PRE_ZERO;
        end else begin
            pre_q <= pre_q + 5'h01;
            kc_q  <= half_tick ? mtx_pkg::PRE_ZERO
                   : base_tick ? kc_q + 5'h01 : kc_q;
        end
    end

    // transfer sequencer; a disable aborts at once and clears status
    always_ff @(posedge clock_i) begin
        if (srst_i || !ctl.en) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
            phase_q <= 1'b0;
            sh_q    <= mtx_pkg::TXBUF_RST;
            idx_q   <= 3'h0;
            rem_q   <= 3'h0;
        end else if (load) begin
            state_q <= ST_SEND;
            busy_q  <= 1'b1;
            phase_q <= 1'b0;
            sh_q    <= head.data;
            idx_q   <= ctl.lsb_first ? 3'h0 : head.last;
            rem_q   <= head.last;
        end else if (half_tick && !phase_q) begin
            phase_q <= 1'b1;
        end else if (bit_end && rem_q == 3'h0) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
            phase_q <= 1'b0;
        end else if (bit_end) begin
            phase_q <= 1'b0;
            rem_q   <= rem_q - 3'h1;
            idx_q   <= ctl.lsb_first ? idx_q + 3'h1 : idx_q - 3'h1;
        end
    end

    // pin, pin release, start request and read data, all registered
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pin_q   <= 1'b0;
            oe_q    <= 1'b0;
            irq_q   <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            pin_q   <= ctl.en ? pin_d : 1'b0;
            oe_q    <= ctl.en;
            irq_q   <= load;
            rdata_q <= !bus_rd_i ? 8'h00
                     : bus_addr_i == mtx_pkg::ADDR_STATUS
                       ? {busy_q, 7'h00}
                     : bus_addr_i == mtx_pkg::ADDR_CTRL0  ? ctrl0_q
                     : bus_addr_i == mtx_pkg::ADDR_CLKSEL ? clksel_q
                     : bus_addr_i == mtx_pkg::ADDR_RATE   ? rate_q
                     : bus_addr_i == mtx_pkg::ADDR_TXBUF  ? txbuf_q
                     : bus_addr_i == mtx_pkg::ADDR_BITCNT ? bitcnt_q
                     : 8'h00;
        end
    end

    assign bus_rdata_o                = rdata_q;
    assign tx_buf_ready_o             = fifo_ready;
    assign coded_output_pin_o         = pin_q;
    assign coded_output_pin_oe_o      = oe_q;
    assign transmit_start_interrupt_o = irq_q;

endmodule : mtx_top

// >>> test/mtx_checker.sv
// port assertions of the coded serial transmitter
`timescale 1ns/1ps
module mtx_checker #(
    parameter int unsigned DEPTH = 16
) (
    input wire logic        clock_i,
    input wire logic        srst_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic        bus_wr_i,
    input wire logic        bus_rd_i,
    input wire logic        bus_bit_i,
    input wire logic [2:0]  bus_bit_sel_i,
    input wire logic [7:0]  bus_wdata_i,
    input wire logic [7:0]  bus_rdata_o,
    input wire logic        tx_buf_ready_o,
    input wire logic        coded_output_pin_o,
    input wire logic        coded_output_pin_oe_o,
    input wire logic        transmit_start_interrupt_o
);
    // ------------------------------------------------------------
    // one clock domain, all checks muted in reset
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);
    // access decode; of a bit write only bit 7 is followed
    wire logic ctl  = bus_wr_i && bus_addr_i == mtx_pkg::ADDR_CTRL0;
    wire logic st_r = bus_rd_i && bus_addr_i == mtx_pkg::ADDR_STATUS;
    wire logic oe   = coded_output_pin_oe_o;
    wire logic irq  = transmit_start_interrupt_o;
    sequence s_enable;
        !oe && ctl && !bus_bit_i && bus_wdata_i[7];
    endsequence
    sequence s_start_read;
        irq && st_r;
    endsequence
    // the control write lands at the first edge and the registered pin
    // follows at the next, so the pin is seen two edges after the write
    property p_enable_idle;
        s_enable |-> ##2 (oe
            && coded_output_pin_o == $past(bus_wdata_i[0], 2));
    endproperty
    a_enable_idle: assert property (p_enable_idle)
        else $error("pin not at idle level after enable");
    property p_bit_enable;
        ctl && bus_bit_i && bus_bit_sel_i == 3'h7
            |-> ##2 oe == $past(bus_wdata_i[0], 2);
    endproperty
    a_bit_enable: assert property (p_bit_enable)
        else $error("bit write of enable not followed");
    property p_released;
        !oe |-> !coded_output_pin_o;
    endproperty
    a_released: assert property (p_released)
        else $error("pin level while released");
    property p_quiet_off;
        !oe [*2] |-> !irq;
    endproperty
    a_quiet_off: assert property (p_quiet_off)
        else $error("start while disabled");
    property p_status_pad;
        st_r |=> bus_rdata_o[6:0] == 7'h00;
    endproperty
    a_status_pad: assert property (p_status_pad)
        else $error("status low bits not zero");
    property p_status_off;
        st_r && !oe |=> bus_rdata_o == 8'h00;
    endproperty
    a_status_off: assert property (p_status_off)
        else $error("status not clear while disabled");
    property p_busy_start;
        s_start_read |=> bus_rdata_o[7];
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy low at byte start");
    property p_irq_pulse;
        irq |=> !irq [*2];
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("start pulse too long");
endmodule : mtx_checker

bind mtx_top mtx_checker #(.DEPTH(DEPTH)) u_checker (
    .clock_i(clock_i), .srst_i(srst_i), .bus_addr_i(bus_addr_i),
    .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_bit_i(bus_bit_i),
    .bus_bit_sel_i(bus_bit_sel_i), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .tx_buf_ready_o(tx_buf_ready_o),
    .coded_output_pin_o(coded_output_pin_o),
    .coded_output_pin_oe_o(coded_output_pin_oe_o),
    .transmit_start_interrupt_o(transmit_start_interrupt_o)
);

// >>> test/mtx_rx_model.sv
// receiver model that samples the coded line mid-half
`timescale 1ns/1ps
module mtx_rx_model (
    input  wire logic        clock_i,
    input  wire logic        start_i,
    input  wire logic        pin_i,
    input  wire logic        seq_i,
    input  wire logic [15:0] half_i,
    input  wire logic [3:0]  nbits_i,
    output logic [7:0]       rx_o,
    output logic             done_o,
    output logic             err_o
);
    int   cnt = 0;
    int   pos;
    logic first_q = 1'b0;
    initial done_o = 1'b1;
    initial err_o = 1'b0;
    initial rx_o = 8'h00;
    // ------------------------------------------------------------
    // decoder
    // ------------------------------------------------------------
    // mid-half sampling tolerates a cycle of skew at either edge
    always @(posedge clock_i) begin
        pos = cnt % (2 * half_i);
        if (start_i) begin
            cnt    <= 1;
            done_o <= 1'b0;
            err_o  <= 1'b0;
            rx_o   <= 8'h00;
        end else if (!done_o) begin
            cnt <= cnt + 1;
            if (pos == half_i / 2)
                first_q <= pin_i;
            if (pos == half_i + half_i / 2) begin
                rx_o <= {rx_o[6:0], pin_i};
                // coded halves differ, plain halves match
                if ((first_q == pin_i) != seq_i)
                    err_o <= 1'b1;
            end
            if (cnt == 2 * half_i * nbits_i - 1)
                done_o <= 1'b1;
        end
    end
endmodule : mtx_rx_model

// >>> test/mtx_tb_top.sv
// self-checking bench of the coded serial transmitter
`timescale 1ns/1ps
module mtx_tb_top;
    logic        clock_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        bbit = 1'b0;
    logic [2:0]  bsel = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata, got, rx;
    logic        ready, pin, oe, irq, done, err;
    logic        seq = 1'b0;
    logic [15:0] half = 16'h0004;
    logic [3:0]  nbits = 4'h8;
    int          fail_count = 0;
    int          total_checks = 0;
    int          n;
    // reset table {address, value}; FF40 is unmapped
    logic [23:0] regs [6] = '{24'hFF47_00, 24'hFF4B_07, 24'hFF4C_10,
                              24'hFF4D_00, 24'hFF4E_1F, 24'hFF40_00};
    // {control, clock select, rate, bit count, data}
    logic [39:0] cases [6] = '{40'h80_01_05_07_A5, 40'h91_04_1F_02_D6,
                               40'h82_02_04_07_3C, 40'h93_03_03_04_5B,
                               40'h80_05_1F_00_01, 40'h80_00_00_01_A6};

    mtx_top u_dut (
        .clock_i(clock_i), .srst_i(srst_i), .bus_addr_i(addr),
        .bus_wr_i(wr), .bus_rd_i(rd), .bus_bit_i(bbit),
        .bus_bit_sel_i(bsel), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
        .tx_buf_ready_o(ready), .coded_output_pin_o(pin),
        .coded_output_pin_oe_o(oe), .transmit_start_interrupt_o(irq)
    );
    mtx_rx_model u_rx (
        .clock_i(clock_i), .start_i(irq), .pin_i(pin), .seq_i(seq),
        .half_i(half), .nbits_i(nbits), .rx_o(rx), .done_o(done),
        .err_o(err)
    );

    // ------------------------------------------------------------
    // clock, tasks
    // ------------------------------------------------------------
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one access, then an idle cycle so strobes never re-rise at once
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(posedge clock_i);
        #1;
        wr = 1'b0;
        rd = 1'b0;
        got = rdata;
        @(posedge clock_i);
        #1;
    endtask : bus
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("register read", e, got);
    endtask : rd_chk
    task automatic bit_wr(input logic v);
        bbit = 1'b1;
        bsel = 3'h7;
        bus(1'b1, mtx_pkg::ADDR_CTRL0, {7'h00, v});
        bbit = 1'b0;
    endtask : bit_wr
    task automatic wait_irq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk("start pulse", 1'b1, irq);
    endtask : wait_irq
    // configure while stopped, send one byte, decode it at the far side
    task automatic run(input logic [39:0] t);
        logic [7:0] e;
        int         h;
        h = (t[20:16] < 5'h04 ? 4 : t[20:16]) << t[27:24];
        e = 8'h00;
        for (int i = 0; i <= t[10:8]; i++)
            e[i] = t[36] ? t[t[10:8] - i] : t[i];
        bus(1'b1, mtx_pkg::ADDR_CTRL0, 8'h00);
        bus(1'b1, mtx_pkg::ADDR_CLKSEL, t[31:24]);
        bus(1'b1, mtx_pkg::ADDR_RATE, t[23:16]);
        bus(1'b1, mtx_pkg::ADDR_BITCNT, t[15:8]);
        bus(1'b1, mtx_pkg::ADDR_CTRL0, t[39:32]);
        chk("idle level", t[32], pin);
        half = h[15:0];
        nbits = t[11:8] + 4'h1;
        seq = t[33];
        bus(1'b1, mtx_pkg::ADDR_TXBUF, t[7:0]);
        wait_irq(4);
        rd_chk(mtx_pkg::ADDR_STATUS, 8'h80);
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk("received bits", e, rx);
        chk("half shape", 1'b0, err);
        repeat (2 * h) @(posedge clock_i);
        #1;
        rd_chk(mtx_pkg::ADDR_STATUS, 8'h00);
        chk("idle after", t[32], pin);
    endtask : run
    task automatic results;
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock_i);
        #1;
        srst_i = 1'b0;
        foreach (regs[i]) rd_chk(regs[i][23:8], regs[i][7:0]);
        bus(1'b1, mtx_pkg::ADDR_STATUS, 8'hFF);
        rd_chk(mtx_pkg::ADDR_STATUS, 8'h00);
        bit_wr(1'b1);
        chk("pin driven", 1'b1, oe);
        bit_wr(1'b0);
        chk("pin released", 1'b0, oe);
        foreach (cases[i]) run(cases[i]);
        // two queued bytes of 16 cycles: the second starts with no gap
        bus(1'b1, mtx_pkg::ADDR_TXBUF, 8'h02);
        wait_irq(4);
        bus(1'b1, mtx_pkg::ADDR_TXBUF, 8'h01);
        wait_irq(40);
        chk("byte gap", 16'h000E, n);
        rd_chk(mtx_pkg::ADDR_STATUS, 8'h80);
        bus(1'b1, mtx_pkg::ADDR_CTRL0, 8'h00);
        chk("abort released", 1'b0, oe);
        rd_chk(mtx_pkg::ADDR_STATUS, 8'h00);
        // queue fill: 20 writes outrun a 32-cycle byte
        bus(1'b1, mtx_pkg::ADDR_CLKSEL, 8'h02);
        bus(1'b1, mtx_pkg::ADDR_BITCNT, 8'h00);
        bus(1'b1, mtx_pkg::ADDR_CTRL0, 8'h80);
        repeat (20) bus(1'b1, mtx_pkg::ADDR_TXBUF, 8'h55);
        chk("queue full", 1'b0, ready);
        n = 0;
        got = 8'h80;
        while (got !== 8'h00 && n < 1000) begin
            bus(1'b0, mtx_pkg::ADDR_STATUS, 8'h00);
            n++;
        end
        chk("drained status", 8'h00, got);
        chk("queue empty", 1'b1, ready);
        bus(1'b1, mtx_pkg::ADDR_CTRL0, 8'h00);
        bus(1'b1, mtx_pkg::ADDR_TXBUF, 8'hAA);
        chk("no start", 1'b0, irq);
        results();
    end
    // watchdog well above the expected run of about 10000 cycles
    initial begin
        #300000;
        fail_count++;
        results();
    end
endmodule : mtx_tb_top
